// File: common/usbsr_pkg.sv
/*
  usbsr_pkg: register map, bit layout, reset values and timing counts for the
  usb suspend/resume and interrupt control block.
  assumes a 20 MHz core clock and an 8-bit register view on a 32-bit wishbone bus.
*/
package usbsr_pkg;

  // core clock
  localparam int CLK_HZ         = 20_000_000;
  localparam int CLK_PERIOD_PS  = 50_000;

  // register byte addresses
  localparam logic [7:0] ADDR_GLOBAL_CONTROL = 8'hbc;
  localparam logic [7:0] ADDR_GLOBAL_FLAG    = 8'hc0;
  localparam logic [7:0] ADDR_GLOBAL_ENABLE  = 8'hc4;
  localparam logic [7:0] ADDR_EP_FLAG        = 8'hc8;
  localparam logic [7:0] ADDR_EP_ENABLE      = 8'hcc;
  localparam logic [7:0] ADDR_PRIORITY       = 8'hd0;

  // global control register fields
  localparam int CTL_CONTROLLER_ON   = 7;
  localparam int CTL_CLOCK_GATE      = 6;
  localparam int CTL_WAKE_SEND       = 5;
  localparam int CTL_RESUME_BUSY     = 3;
  localparam int CTL_WAKE_ALLOW      = 2;
  localparam int CTL_CONFIGURED      = 1;
  localparam int CTL_ADDRESS_VALID   = 0;
  localparam logic [7:0] CTL_RESET   = 8'h00;

  // global flag and enable fields
  localparam int GF_WAKE             = 5;
  localparam int GF_END_OF_RESET     = 4;
  localparam int GF_FRAME_START      = 3;
  localparam int GF_SUSPEND          = 0;
  localparam logic [7:0] GF_MASK     = 8'h39;
  localparam logic [7:0] GEN_RESET   = 8'h10;

  // endpoint flag and enable fields
  localparam int EF_IN_SENT          = 0;
  localparam int EF_OUT_BANK0        = 1;
  localparam int EF_SETUP_RECEIVED   = 2;
  localparam int EF_STALL_SENT       = 3;
  localparam int EF_OUT_BANK1        = 6;
  localparam logic [7:0] EF_MASK     = 8'h4f;
  localparam logic [7:0] EEN_RESET   = 8'h00;

  // priority register fields
  localparam int PRI_LOW_BIT         = 0;
  localparam int PRI_HIGH_BIT        = 1;
  localparam logic [7:0] PRI_MASK    = 8'h03;

  // times as printed, and their cycle counts
  localparam int SUSPEND_IDLE_US     = 3000;
  localparam int REMOTE_MIN_US       = 5000;
  localparam int RESUME_DRIVE_US     = 10000;
  localparam int BUS_RESET_BITS      = 32;
  localparam int FS_BIT_PS           = 83_333;
  localparam int SUSPEND_CYC         = SUSPEND_IDLE_US * (CLK_HZ / 1_000_000) + 1;
  localparam int REMOTE_MIN_CYC      = REMOTE_MIN_US * (CLK_HZ / 1_000_000);
  localparam int RESUME_DRIVE_CYC    = RESUME_DRIVE_US * (CLK_HZ / 1_000_000);
  localparam int BUS_RESET_CYC       = (BUS_RESET_BITS * FS_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : usbsr_pkg

// File: verilog/usbsr_timer.sv
/*
  usbsr_timer: saturating cycle counter with a reached flag.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module usbsr_timer #(
  parameter int WIDTH = 18,
  parameter int LIMIT = 1
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_clear,
  input  wire logic i_run,
  // status
  output logic      o_done
);

  logic [WIDTH-1:0] count;

  // the limit must fit the counter and be at least one cycle
  if (LIMIT < 1 || LIMIT >= (2 ** WIDTH)) begin : g_bad_limit
    $error("usbsr_timer: limit does not fit the counter");
  end

  assign o_done = (count >= LIMIT[WIDTH-1:0]);

  // count while running, hold once the limit is reached
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || i_clear)
      count <= '0;
    else if (i_run && !o_done)
      count <= count + 1'b1;
  end

endmodule // usbsr_timer

`default_nettype wire

// File: verilog/usbsr_flag.sv
/*
  usbsr_flag: one sticky event flag; a set in the same cycle as a clear wins.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module usbsr_flag (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // events
  input  wire logic i_set,
  input  wire logic i_clr,
  // state
  output logic      o_flag
);

  // set has priority so an event on the clearing cycle is kept
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_flag <= 1'b0;
    else
      o_flag <= i_set | (o_flag & ~i_clr);
  end

endmodule // usbsr_flag

`default_nettype wire

// File: verilog/usbsr_ctrl.sv
/*
  usbsr_ctrl: suspend detection, pad idle and resume handling, upstream resume
  sequencing, bus reset handling of the control bits, and the usb interrupt
  flag, enable and priority registers, reached over classic wishbone.
  assumes the line receiver reports idle (j) and se0 levels synchronous to the
  core clock, and the packet engine gives one-cycle event pulses.
*/
`timescale 1ns/100ps
`default_nettype none

module usbsr_ctrl
  import usbsr_pkg::*;
#(
  parameter int SUSPEND_CYC      = usbsr_pkg::SUSPEND_CYC,
  parameter int REMOTE_MIN_CYC   = usbsr_pkg::REMOTE_MIN_CYC,
  parameter int RESUME_DRIVE_CYC = usbsr_pkg::RESUME_DRIVE_CYC,
  parameter int TIMER_WIDTH      = 18
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  // bus line state and pll
  input  wire logic        i_bus_idle,
  input  wire logic        i_bus_se0,
  input  wire logic        i_pll_on,
  // packet engine events for the selected endpoint
  input  wire logic        i_sof_rx,
  input  wire logic        i_in_acked,
  input  wire logic        i_out_bank0,
  input  wire logic        i_out_bank1,
  input  wire logic        i_setup_rx,
  input  wire logic        i_stall_sent,
  input  wire logic        i_ep_pingpong,
  input  wire logic        i_ep_iso,
  // transceiver and clock control
  output logic             o_xcvr_on,
  output logic             o_usb_clk_en,
  output logic             o_ctrl_rst,
  output logic             o_pad_idle,
  output logic             o_resume_drive,
  output logic             o_configured,
  output logic             o_address_valid,
  // interrupt request
  output logic             o_irq,
  output logic [1:0]       o_irq_prio
);

  import usbsr_pkg::*;

  // register state
  logic       controller_on;
  logic       clock_gate_bit;
  logic       remote_wake_send;
  logic       remote_wake_allow;
  logic       configured_bit;
  logic       address_valid;
  logic       upstream_resume_busy;
  logic [7:0] global_flag_enable_reg;
  logic [7:0] ep_enable;
  logic [7:0] prio;
  logic [7:0] global_flag_reg;
  logic [7:0] ep_flag;
  // link state
  logic       suspended;
  logic       suspend_done_q;
  logic       reset_seen;
  logic       pad_idle;
  logic       resume_drive;
  // timer outputs
  logic       suspend_done;
  logic       remote_ready;
  logic       drive_done;
  logic       bus_reset_done;
  // decoded strobes and events
  logic       wb_req;
  logic       wr_ctl;
  logic       wr_gflag;
  logic       wr_ep;
  logic       clocks_run;
  logic       suspend_evt;
  logic       wake_evt;
  logic       bus_reset;
  logic       eor_evt;
  logic       flags_rst;
  logic [7:0] next_wdat;
  logic [7:0] g_set;
  logic [7:0] g_clr;
  logic [7:0] e_set;
  logic [7:0] e_clr;

  // elaboration checks on the counters
  if (TIMER_WIDTH < 8 || TIMER_WIDTH > 30) begin : g_bad_width
    $error("usbsr_ctrl: timer width out of range");
  end

  // wishbone decode; byte lane 0 carries the 8-bit registers
  assign wb_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign next_wdat = i_wb_dat[7:0];
  assign wr_ctl    = wb_req & i_wb_we & i_wb_sel[0] & (i_wb_adr == ADDR_GLOBAL_CONTROL);
  assign wr_gflag  = wb_req & i_wb_we & i_wb_sel[0] & (i_wb_adr == ADDR_GLOBAL_FLAG);
  assign wr_ep     = wb_req & i_wb_we & i_wb_sel[0] & (i_wb_adr == ADDR_EP_FLAG);

  // clock availability and controller reset
  assign clocks_run   = controller_on & ~clock_gate_bit & i_pll_on;
  assign flags_rst    = i_rst | ~controller_on;
  assign o_xcvr_on    = controller_on;
  assign o_usb_clk_en = controller_on & ~clock_gate_bit;
  assign o_ctrl_rst   = ~controller_on;

  // idle-bus timer for suspend detection, only with clocks running
  usbsr_timer #(
    .WIDTH (TIMER_WIDTH),
    .LIMIT (SUSPEND_CYC)
  ) u_suspend_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (flags_rst),
    .i_clear    (~i_bus_idle | ~clocks_run),
    .i_run      (clocks_run),
    .o_done     (suspend_done)
  );

  // time spent suspended, gating remote wake
  usbsr_timer #(
    .WIDTH (TIMER_WIDTH),
    .LIMIT (REMOTE_MIN_CYC)
  ) u_remote_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (flags_rst),
    .i_clear    (~suspended),
    .i_run      (1'b1),
    .o_done     (remote_ready)
  );

  // length of the driven resume signalling
  usbsr_timer #(
    .WIDTH (TIMER_WIDTH),
    .LIMIT (RESUME_DRIVE_CYC)
  ) u_drive_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (flags_rst),
    .i_clear    (~resume_drive),
    .i_run      (1'b1),
    .o_done     (drive_done)
  );

  // se0 length for bus reset
  usbsr_timer #(
    .WIDTH (TIMER_WIDTH),
    .LIMIT (BUS_RESET_CYC)
  ) u_reset_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (flags_rst),
    .i_clear    (~i_bus_se0),
    .i_run      (1'b1),
    .o_done     (bus_reset_done)
  );

  // events derived from bus state
  assign suspend_evt = suspend_done & ~suspend_done_q;
  assign wake_evt    = suspended & ~i_bus_idle & ~resume_drive;
  assign bus_reset   = bus_reset_done;
  assign eor_evt     = reset_seen & ~i_bus_se0;

  // edge memory for the suspend timer and bus reset tracking
  always_ff @(posedge i_core_clk)
  begin
    if (flags_rst)
    begin
      suspend_done_q <= 1'b0;
      reset_seen     <= 1'b0;
    end
    else
    begin
      suspend_done_q <= suspend_done;
      reset_seen     <= bus_reset | (reset_seen & i_bus_se0);
    end
  end

  // suspended state; runs on the core clock so it survives usb clock gating
  always_ff @(posedge i_core_clk)
  begin
    if (flags_rst)
      suspended <= 1'b0;
    else if (suspend_evt)
      suspended <= 1'b1;
    else if (wake_evt || (resume_drive && drive_done))
      suspended <= 1'b0;
  end

  // pad idle: entered when firmware clears the suspend flag, left on wake
  always_ff @(posedge i_core_clk)
  begin
    if (flags_rst)
      pad_idle <= 1'b0;
    else if (wake_evt || resume_drive)
      pad_idle <= 1'b0;
    else if (wr_gflag && !next_wdat[GF_SUSPEND] && global_flag_reg[GF_SUSPEND] && suspended)
      pad_idle <= 1'b1;
  end
  assign o_pad_idle = pad_idle;

  // upstream resume busy and drive sequencing
  always_ff @(posedge i_core_clk)
  begin
    if (flags_rst)
    begin
      upstream_resume_busy <= 1'b0;
      resume_drive         <= 1'b0;
    end
    else
    begin
      if (resume_drive && drive_done)
      begin
        resume_drive         <= 1'b0;
        upstream_resume_busy <= 1'b0;
      end
      else if (upstream_resume_busy && !resume_drive && remote_wake_allow
               && clocks_run && remote_ready && suspended)
        resume_drive <= 1'b1;
      else if (remote_wake_send && remote_wake_allow && !resume_drive && suspended)
        upstream_resume_busy <= 1'b1;
    end
  end
  assign o_resume_drive = resume_drive;

  // global control register; bus reset clears configured and address valid
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      controller_on     <= CTL_RESET[CTL_CONTROLLER_ON];
      clock_gate_bit    <= CTL_RESET[CTL_CLOCK_GATE];
      remote_wake_send  <= CTL_RESET[CTL_WAKE_SEND];
      remote_wake_allow <= CTL_RESET[CTL_WAKE_ALLOW];
      configured_bit    <= CTL_RESET[CTL_CONFIGURED];
      address_valid     <= CTL_RESET[CTL_ADDRESS_VALID];
    end
    else
    begin
      if (wr_ctl)
      begin
        controller_on     <= next_wdat[CTL_CONTROLLER_ON];
        clock_gate_bit    <= next_wdat[CTL_CLOCK_GATE];
        remote_wake_send  <= next_wdat[CTL_WAKE_SEND];
        remote_wake_allow <= next_wdat[CTL_WAKE_ALLOW];
        configured_bit    <= next_wdat[CTL_CONFIGURED];
        address_valid     <= next_wdat[CTL_ADDRESS_VALID];
      end
      if (bus_reset || !controller_on)
      begin
        configured_bit <= 1'b0;
        address_valid  <= 1'b0;
      end
    end
  end
  assign o_configured    = configured_bit;
  assign o_address_valid = address_valid;

  // enable and priority registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      global_flag_enable_reg <= GEN_RESET;
      ep_enable              <= EEN_RESET;
      prio                   <= 8'h00;
    end
    else if (wb_req && i_wb_we && i_wb_sel[0])
    begin
      if (i_wb_adr == ADDR_GLOBAL_ENABLE)
        global_flag_enable_reg <= next_wdat & GF_MASK;
      if (i_wb_adr == ADDR_EP_ENABLE)
        ep_enable <= next_wdat & EF_MASK;
      if (i_wb_adr == ADDR_PRIORITY)
        prio <= next_wdat & PRI_MASK;
    end
  end

  // set and clear terms; writing 0 to a flag bit clears it
  always_comb
  begin
    g_set = 8'h00;
    g_set[GF_SUSPEND]      = suspend_evt;
    g_set[GF_WAKE]         = wake_evt;
    g_set[GF_FRAME_START]  = i_sof_rx;
    g_set[GF_END_OF_RESET] = eor_evt;
    g_clr = wr_gflag ? ~next_wdat : 8'h00;
    e_set = 8'h00;
    e_set[EF_IN_SENT]        = i_in_acked;
    e_set[EF_OUT_BANK0]      = i_out_bank0;
    e_set[EF_SETUP_RECEIVED] = i_setup_rx;
    e_set[EF_STALL_SENT]     = i_stall_sent & ~i_ep_iso & ~i_setup_rx;
    e_set[EF_OUT_BANK1]      = i_out_bank1 & i_ep_pingpong;
    e_clr = wr_ep ? ~next_wdat : 8'h00;
    e_clr[EF_STALL_SENT] = e_clr[EF_STALL_SENT] | i_setup_rx;
  end

  // sticky flags, one per implemented bit
  for (genvar b = 0; b < 8; b++) begin : g_flags
    if (GF_MASK[b]) begin : g_glb
      usbsr_flag u_glb (
        .i_core_clk (i_core_clk),
        .i_rst      (flags_rst),
        .i_set      (g_set[b]),
        .i_clr      (g_clr[b]),
        .o_flag     (global_flag_reg[b])
      );
    end
    else begin : g_glb_rsvd
      assign global_flag_reg[b] = 1'b0;
    end
    if (EF_MASK[b]) begin : g_ep
      usbsr_flag u_ep (
        .i_core_clk (i_core_clk),
        .i_rst      (flags_rst),
        .i_set      (e_set[b]),
        .i_clr      (e_clr[b]),
        .o_flag     (ep_flag[b])
      );
    end
    else begin : g_ep_rsvd
      assign ep_flag[b] = 1'b0;
    end
  end

  // single interrupt request at the programmed priority
  assign o_irq      = |(global_flag_reg & global_flag_enable_reg) | |(ep_flag & ep_enable);
  assign o_irq_prio = {prio[PRI_HIGH_BIT], prio[PRI_LOW_BIT]};

  // wishbone answer: ack one cycle after the request, registered read data
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we)
      begin
        unique case (i_wb_adr)
          ADDR_GLOBAL_CONTROL: o_wb_dat <= {24'h000000, controller_on, clock_gate_bit, remote_wake_send, 1'b0,
                                            upstream_resume_busy, remote_wake_allow, configured_bit, address_valid};
          ADDR_GLOBAL_FLAG:    o_wb_dat <= {24'h000000, global_flag_reg};
          ADDR_GLOBAL_ENABLE:  o_wb_dat <= {24'h000000, global_flag_enable_reg};
          ADDR_EP_FLAG:        o_wb_dat <= {24'h000000, ep_flag};
          ADDR_EP_ENABLE:      o_wb_dat <= {24'h000000, ep_enable};
          ADDR_PRIORITY:       o_wb_dat <= {24'h000000, prio};
          default:             o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // usbsr_ctrl

`default_nettype wire

// File: testbench/usbsr_host_model.sv
/*
  usbsr_host_model: host side of the full-speed line, as seen by the block.
  assumes the bench picks the line behaviour; changes follow the core clock.
*/
`timescale 1ns/100ps
`default_nettype none

module usbsr_host_model (
  // clock
  input  wire logic       i_core_clk,
  // line behaviour: 0 idle j, 1 traffic, 2 bus reset se0
  input  wire logic [1:0] i_mode,
  // line state and frame events
  output logic            o_bus_idle,
  output logic            o_bus_se0,
  output logic            o_sof
);
  // frame phase starts known so traffic is defined from the first edge
  logic [3:0] phase = 4'h0;

  // traffic toggles j/k every cycle with a frame start every 16 cycles
  always @(posedge i_core_clk)
  begin
    phase      <= phase + 4'h1;
    o_bus_idle <= (i_mode == 2'h0) || (i_mode == 2'h1 && phase[0]);
    o_bus_se0  <= (i_mode == 2'h2);
    o_sof      <= (i_mode == 2'h1) && (phase == 4'hf);
  end
endmodule // usbsr_host_model

`default_nettype wire

// File: testbench/usbsr_ctrl_asserts.sv
/*
  usbsr_ctrl_asserts: port-level checks of the suspend/resume block.
  assumes it is bound into usbsr_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module usbsr_ctrl_asserts
  import usbsr_pkg::*;
#(
  parameter int RESUME_DRIVE_CYC = 10
) (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  // wishbone
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic        o_wb_ack,
  // line and control outputs
  input wire logic        i_bus_idle,
  input wire logic        i_bus_se0,
  input wire logic        i_pll_on,
  input wire logic        o_xcvr_on,
  input wire logic        o_usb_clk_en,
  input wire logic        o_ctrl_rst,
  input wire logic        o_pad_idle,
  input wire logic        o_resume_drive,
  input wire logic        o_configured,
  input wire logic        o_address_valid,
  input wire logic        o_irq,
  input wire logic [1:0]  o_irq_prio
);
  int unsigned se0_cnt;
  int unsigned drive_cnt;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // length of the current se0 stretch
  always_ff @(posedge i_core_clk)
    se0_cnt <= (i_rst || !i_bus_se0) ? 0 : se0_cnt + 1;

  // length of the current resume drive
  always_ff @(posedge i_core_clk)
    drive_cnt <= (i_rst || !o_resume_drive) ? 0 : drive_cnt + 1;

  sequence wb_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence

  sequence prio_wr;
    wb_req ##0 (i_wb_we && i_wb_sel[0] && i_wb_adr == ADDR_PRIORITY);
  endsequence

  chk_ack_next: assert property (wb_req |=> o_wb_ack)
    else $error("ack missing after request");
  chk_ack_once: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_prio_code: assert property (prio_wr |=> o_irq_prio == $past(i_wb_dat[1:0]))
    else $error("priority code differs from written bits");
  chk_off_state: assert property (!o_xcvr_on ##1 !o_xcvr_on |->
    !o_configured && !o_address_valid && !o_irq && !o_pad_idle)
    else $error("state kept while controller off");
  chk_off_clock: assert property (o_ctrl_rst != o_xcvr_on && !(o_usb_clk_en && !o_xcvr_on))
    else $error("reset or clock enable wrong for controller state");
  chk_bus_reset: assert property (se0_cnt > BUS_RESET_CYC |-> !o_configured && !o_address_valid)
    else $error("control bits kept through bus reset");
  chk_pad_wake: assert property (o_pad_idle && !i_bus_idle && !o_resume_drive |=> !o_pad_idle)
    else $error("pad stayed idle on bus activity");
  // the drive starts one cycle before its timer counts, so it stands limit + 1 cycles
  chk_drive_len: assert property ($fell(o_resume_drive) |-> drive_cnt == RESUME_DRIVE_CYC + 1)
    else $error("resume drive length wrong");
  chk_drive_clk: assert property (o_resume_drive |-> o_usb_clk_en && i_pll_on)
    else $error("resume driven without running clocks");
endmodule // usbsr_ctrl_asserts

bind usbsr_ctrl usbsr_ctrl_asserts #(.RESUME_DRIVE_CYC(RESUME_DRIVE_CYC)) u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .i_bus_idle(i_bus_idle), .i_bus_se0(i_bus_se0), .i_pll_on(i_pll_on),
  .o_xcvr_on(o_xcvr_on), .o_usb_clk_en(o_usb_clk_en), .o_ctrl_rst(o_ctrl_rst),
  .o_pad_idle(o_pad_idle), .o_resume_drive(o_resume_drive), .o_configured(o_configured),
  .o_address_valid(o_address_valid), .o_irq(o_irq), .o_irq_prio(o_irq_prio));

`default_nettype wire

// File: testbench/tb_top.sv
/*
  tb_top: self-checking bench for usbsr_ctrl with a host line model.
  assumes shortened suspend, remote wake and drive counts.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import usbsr_pkg::*;
  localparam int T_SUSP = 20;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, pll = 1'b1, pp = 1'b0, iso = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, o_wb_dat;
  logic [4:0] ev = 5'h00;
  logic [3:0] sel = 4'h1;
  logic [1:0] mode = 2'h1, o_irq_prio;
  logic bidle, bse0, sof, o_wb_ack, xcvr, clken, crst, pad, drive, cfg, aval, irq;
  int mismatches = 0, check_count = 0;

  // 20 MHz core clock
  always #25 clk = ~clk;

  usbsr_host_model u_host (.i_core_clk(clk), .i_mode(mode), .o_bus_idle(bidle), .o_bus_se0(bse0), .o_sof(sof));

  usbsr_ctrl #(.SUSPEND_CYC(T_SUSP), .REMOTE_MIN_CYC(30), .RESUME_DRIVE_CYC(10)) DUT (
    .i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_bus_idle(bidle),
    .i_bus_se0(bse0), .i_pll_on(pll), .i_sof_rx(sof), .i_in_acked(ev[0]), .i_out_bank0(ev[1]),
    .i_out_bank1(ev[4]), .i_setup_rx(ev[2]), .i_stall_sent(ev[3]), .i_ep_pingpong(pp),
    .i_ep_iso(iso), .o_xcvr_on(xcvr), .o_usb_clk_en(clken), .o_ctrl_rst(crst), .o_pad_idle(pad),
    .o_resume_drive(drive), .o_configured(cfg), .o_address_valid(aval), .o_irq(irq),
    .o_irq_prio(o_irq_prio));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge clk);
    // only the watchdog ends a wait for the answer
    while (o_wb_ack !== 1'b1)
      @(posedge clk);
    rdat = o_wb_dat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(name, rdat, {24'h0, e});
  endtask

  task automatic pulse(input logic [4:0] e);
    ev <= e;
    @(posedge clk);
    ev <= 5'h00;
    @(posedge clk);
  endtask

  task automatic t_reset();
    chk("ctrl_rst", {31'h0, crst}, 32'h1);
    rdchk("ctl", ADDR_GLOBAL_CONTROL, 8'h00);
    rdchk("gen", ADDR_GLOBAL_ENABLE, GEN_RESET);
    rdchk("unmapped", 8'hf0, 8'h00);
    wb(1'b1, ADDR_GLOBAL_CONTROL, 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, ADDR_PRIORITY, 8'(i));
      chk("prio", {30'h0, o_irq_prio}, 32'(i));
    end
    $display("test reset_prio done");
  endtask

  task automatic t_events();
    wb(1'b1, ADDR_EP_ENABLE, EF_MASK);
    wb(1'b1, ADDR_GLOBAL_ENABLE, 8'h08);
    wb(1'b1, ADDR_GLOBAL_FLAG, 8'h00);
    pulse(5'h01);
    pulse(5'h02);
    pulse(5'h08);
    pulse(5'h10);
    rdchk("ep", ADDR_EP_FLAG, 8'h0b);
    chk("irq", {31'h0, irq}, 32'h1);
    pulse(5'h04);
    rdchk("ep", ADDR_EP_FLAG, 8'h07);
    pp <= 1'b1;
    iso <= 1'b1;
    pulse(5'h18);
    rdchk("ep", ADDR_EP_FLAG, 8'h47);
    wb(1'b1, ADDR_EP_FLAG, 8'h00);
    rdchk("gf", ADDR_GLOBAL_FLAG, 8'h08);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, ADDR_GLOBAL_ENABLE, 8'h00);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test events done");
  endtask

  task automatic t_suspend();
    // line goes idle first so no late frame start survives the flag clear
    mode <= 2'h0;
    wb(1'b1, ADDR_GLOBAL_ENABLE, 8'h21);
    wb(1'b1, ADDR_GLOBAL_FLAG, 8'h00);
    repeat (T_SUSP + 10) @(posedge clk);
    rdchk("gf", ADDR_GLOBAL_FLAG, 8'h01);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, ADDR_GLOBAL_FLAG, 8'h00);
    chk("pad", {31'h0, pad}, 32'h1);
    wb(1'b1, ADDR_GLOBAL_CONTROL, 8'hc0);
    pll <= 1'b0;
    chk("clken", {31'h0, clken}, 32'h0);
    repeat (2 * T_SUSP) @(posedge clk);
    rdchk("gf", ADDR_GLOBAL_FLAG, 8'h00);
    mode <= 2'h1;
    repeat (4) @(posedge clk);
    chk("pad", {31'h0, pad}, 32'h0);
    wb(1'b0, ADDR_GLOBAL_FLAG, 8'h00);
    chk("gf", rdat & 32'h21, 32'h20);
    pll <= 1'b1;
    wb(1'b1, ADDR_GLOBAL_CONTROL, 8'h80);
    chk("clken", {31'h0, clken}, 32'h1);
    wb(1'b1, ADDR_GLOBAL_FLAG, 8'h00);
    $display("test suspend done");
  endtask

  task automatic t_remote();
    int n;
    n = 0;
    mode <= 2'h0;
    repeat (T_SUSP + 10) @(posedge clk);
    wb(1'b1, ADDR_GLOBAL_FLAG, 8'h00);
    wb(1'b1, ADDR_GLOBAL_CONTROL, 8'ha0);
    rdchk("ctl", ADDR_GLOBAL_CONTROL, 8'ha0);
    wb(1'b1, ADDR_GLOBAL_CONTROL, 8'ha4);
    rdchk("ctl", ADDR_GLOBAL_CONTROL, 8'hac);
    while (drive !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge clk);
    end
    chk("drive", {31'h0, drive}, 32'h1);
    repeat (12) @(posedge clk);
    rdchk("ctl", ADDR_GLOBAL_CONTROL, 8'ha4);
    mode <= 2'h1;
    wb(1'b1, ADDR_GLOBAL_CONTROL, 8'h80);
    wb(1'b1, ADDR_GLOBAL_FLAG, 8'h00);
    $display("test remote done");
  endtask

  task automatic t_busreset_off();
    wb(1'b1, ADDR_GLOBAL_CONTROL, 8'h83);
    chk("cfg", {30'h0, cfg, aval}, 32'h3);
    mode <= 2'h2;
    repeat (BUS_RESET_CYC + 4) @(posedge clk);
    chk("cfg", {30'h0, cfg, aval}, 32'h0);
    mode <= 2'h1;
    repeat (4) @(posedge clk);
    wb(1'b0, ADDR_GLOBAL_FLAG, 8'h00);
    chk("eor", rdat & 32'h10, 32'h10);
    rdchk("ctl", ADDR_GLOBAL_CONTROL, 8'h80);
    wb(1'b1, ADDR_GLOBAL_ENABLE, 8'h10);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, ADDR_GLOBAL_CONTROL, 8'h03);
    chk("off", {28'h0, xcvr, crst, clken, irq}, 32'h4);
    $display("test busreset_off done");
  endtask

  // stops a hung run
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_suspend();
    t_remote();
    t_busreset_off();
    end_sim();
  end
endmodule // tb_top

`default_nettype wire
